/* File: evt_defines.vh */
// Constants for the timer-synchronised event I/O block.
// Included by evt_io_timer_sync.v; definitions only.
`ifndef EVT_DEFINES_VH
`define EVT_DEFINES_VH
// Clock generator: phase ticks per state time
`define EVT_PHASES_PER_STATE 2'h3
`define EVT_PHASE_A 2'h0
`define EVT_PHASE_B 2'h1
// Base timer increments when the state count reaches this value, once per eight state times
`define EVT_STATES_PER_TICK 3'h7
// Pulse-width output period in ns, and its length in system clocks
`define EVT_PWM_PERIOD_NS 64000
`define EVT_PWM_CYCLES (`EVT_PWM_PERIOD_NS / 50)
// Event output waveform limits
`define EVT_DUTY_STEPS 65536
`define EVT_MAX_PERIOD_MS 131
`endif

/* File: evt_io_timer_sync.v */
// Timer-synchronised event I/O: base timer, second timer, event outputs,
// sampled event inputs and a fixed-period pulse-width output.
// Assumes one 20 MHz clock; pins arrive asynchronously.
// Function
// - Event output changes all apply just before base timer increments.
// - Outputs update at the end of the third phase, once every eight state times.
// - Outputs change before buffered clock rise, settled by its fall.
// - Internal events may occur anywhere in the eight-state window.
// - Second timer never increments faster than the base timer.
// - Every event input pin sampled at most once per state time.
// - Input sample taken at buffered clock rise, judged in phase B.
// - One-state stability still applies in divide-by-eight counting mode.
// - Two events on one pin within a window record once.
// - Events on different pins are always all recorded.
// - Window is eight state times of constant base timer value.
// - Event outputs allow 65536 duty steps, period up to 131 ms; here the base timer wraps after 65536 ticks of 1.2 us, about 78.6 ms.
// - Pulse-width output has fixed 64 us period, duty programmable.
// - Both outputs give variable duty; only event outputs vary period.
`timescale 1ns/1ps
`default_nettype none
`include "evt_defines.vh"
module evt_io_timer_sync #(
  parameter N_OUT = 4,
  parameter N_IN = 4,
  parameter PWM_CYCLES = `EVT_PWM_CYCLES
) (
  input wire clk_sys_i,
  input wire reset_i,
  input wire [N_OUT-1:0] sched_value_i,
  input wire [N_OUT-1:0] sched_mask_i,
  input wire [15:0] sched_time_i,
  input wire sched_valid_i,
  input wire timer2_ext_i,
  input wire [N_IN-1:0] event_input_pins_i,
  input wire [N_IN-1:0] div8_mode_i,
  input wire [N_IN-1:0] evt_ack_i,
  input wire [11:0] pwm_duty_i,
  output reg [N_OUT-1:0] event_output_lines_o,
  output reg buffered_clock_output_o,
  output reg [15:0] base_timer_o,
  output reg [15:0] timer2_o,
  output reg [N_IN-1:0] evt_pending_o,
  output reg [15:0] evt_stamp_o,
  output reg [N_IN-1:0] evt_level_o,
  output reg pwm_o
);
  reg [1:0] phase;
  reg [2:0] state_cnt;
  reg [N_OUT-1:0] pend_val;
  reg [N_OUT-1:0] pend_mask;
  reg [15:0] pend_time;
  reg pend_armed;
  reg t2_req;
  reg [2:0] t2_sync;
  reg [11:0] pwm_cnt;
  reg [11:0] duty_hold;
  reg t2_level;
  wire t2_rise;
  wire [N_IN-1:0] rec;
  wire [N_IN-1:0] next_pending;
  wire [N_IN-1:0] next_level;
  wire phase_end;
  wire tick;
  wire sample_now;
  assign phase_end = (phase == `EVT_PHASES_PER_STATE - 2'h1);
  // Base timer moves at the end of the third phase of the eighth state time
  assign tick = phase_end && (state_cnt == `EVT_STATES_PER_TICK);
  // Judged in phase B: the pair read then is the pin as seen at the
  // buffered clock rise, two sync stages back
  assign sample_now = (phase == `EVT_PHASE_B);

  // Three internal phases per state; buffered clock high in phase A only,
  // so its rise follows the tick that moves the outputs.
  always @(posedge clk_sys_i) begin
    if (reset_i) begin
      phase <= 2'h0;
      state_cnt <= 3'h0;
      buffered_clock_output_o <= 1'b0;
    end else begin
      phase <= phase_end ? 2'h0 : phase + 2'h1;
      if (phase_end) begin
        state_cnt <= state_cnt + 3'h1;
      end
      buffered_clock_output_o <= phase_end;
    end
  end

  // Base timer, eight state times per count
  always @(posedge clk_sys_i) begin
    if (reset_i) begin
      base_timer_o <= 16'h0000;
    end else if (tick) begin
      base_timer_o <= base_timer_o + 16'h0001;
    end
  end

  // Schedule slot: host may load any time in window
  always @(posedge clk_sys_i) begin
    if (reset_i) begin
      pend_val <= {N_OUT{1'b0}};
      pend_mask <= {N_OUT{1'b0}};
      pend_time <= 16'h0000;
      pend_armed <= 1'b0;
      event_output_lines_o <= {N_OUT{1'b0}};
    end else begin
      // Apply all matching lines together on the tick
      if (tick && pend_armed && pend_time == base_timer_o) begin
        event_output_lines_o <= (event_output_lines_o & ~pend_mask) |
          (pend_val & pend_mask);
        pend_armed <= 1'b0;
      end
      // A new load wins over the completion in the same cycle
      if (sched_valid_i) begin
        pend_val <= sched_value_i;
        pend_mask <= sched_mask_i;
        pend_time <= sched_time_i;
        pend_armed <= 1'b1;
      end
    end
  end

  // Second timer pin: a rise counts once sync stages two and three agree
  assign t2_rise = (t2_sync[2] == t2_sync[1]) && t2_sync[1] && !t2_level;

  // Second timer: request held until the base tick grants it
  always @(posedge clk_sys_i) begin
    if (reset_i) begin
      t2_sync <= 3'h0;
      t2_level <= 1'b0;
      t2_req <= 1'b0;
      timer2_o <= 16'h0000;
    end else begin
      t2_sync <= {t2_sync[1:0], timer2_ext_i};
      if (t2_sync[2] == t2_sync[1]) begin
        t2_level <= t2_sync[1];
      end
      // At most one count per tick, never faster than base
      if (tick && t2_req) begin
        timer2_o <= timer2_o + 16'h0001;
      end
      // A fresh rise beats the grant, so it is not lost
      if (t2_rise) begin
        t2_req <= 1'b1;
      end else if (tick) begin
        t2_req <= 1'b0;
      end
    end
  end

  // Event inputs: one sampler per pin so pins never block each other
  genvar g;
  generate
    for (g = 0; g < N_IN; g = g + 1) begin : g_in
      reg [2:0] sync;
      reg agreed;
      reg [2:0] div_cnt;
      reg seen;
      wire stable_now;
      wire edge_hit;
      wire div_hit;
      // Sample once per state time, only when stages two and three agree
      assign stable_now = sample_now && (sync[2] == sync[1]);
      // Edge counts once sync stages two and three agree
      assign edge_hit = stable_now && (sync[1] != agreed) && sync[1];
      assign div_hit = div8_mode_i[g] ? (div_cnt == 3'h7) : 1'b1;
      // Only the first event per window on this pin is kept
      assign rec[g] = edge_hit && div_hit && !seen;
      // Set beats acknowledge in the same cycle
      assign next_pending[g] = rec[g] | (evt_pending_o[g] & ~evt_ack_i[g]);
      assign next_level[g] = stable_now ? sync[1] : evt_level_o[g];
      always @(posedge clk_sys_i) begin
        if (reset_i) begin
          sync <= 3'h0;
          agreed <= 1'b0;
          div_cnt <= 3'h0;
          seen <= 1'b0;
        end else begin
          sync <= {sync[1:0], event_input_pins_i[g]};
          if (stable_now) begin
            agreed <= sync[1];
          end
          // Divider runs only in its mode, so older edges leave no phase
          if (edge_hit && div8_mode_i[g]) begin
            div_cnt <= div_cnt + 3'h1;
          end
          if (tick) begin
            seen <= 1'b0;
          end else if (edge_hit && div_hit) begin
            seen <= 1'b1;
          end
        end
      end
    end
  endgenerate

  // Flags and levels in one process so each output has a single driver
  always @(posedge clk_sys_i) begin
    if (reset_i) begin
      evt_pending_o <= {N_IN{1'b0}};
      evt_level_o <= {N_IN{1'b0}};
    end else begin
      evt_pending_o <= next_pending;
      evt_level_o <= next_level;
    end
  end

  // Stamp of last recorded event, any pin; pins recorded in one
  // sample share a single stamp
  always @(posedge clk_sys_i) begin
    if (reset_i) begin
      evt_stamp_o <= 16'h0000;
    end else if (|rec) begin
      evt_stamp_o <= base_timer_o;
    end
  end

  // Pulse-width output: fixed period, duty only
  always @(posedge clk_sys_i) begin
    if (reset_i) begin
      pwm_cnt <= 12'h000;
      duty_hold <= 12'h000;
      pwm_o <= 1'b0;
    end else begin
      // Duty taken only at period start; a mid-period write cannot
      // cut a period short
      if (pwm_cnt == PWM_CYCLES - 1) begin
        pwm_cnt <= 12'h000;
        duty_hold <= pwm_duty_i;
      end else begin
        pwm_cnt <= pwm_cnt + 12'h001;
      end
      pwm_o <= (pwm_cnt < duty_hold);
    end
  end
endmodule
`default_nettype wire

/* File: evt_chk_sva.sv */
// Timing checker for the event I/O block.
// Bound to the top module; sees its ports only.
`timescale 1ns/1ps
`default_nettype none
module evt_chk #(parameter N_OUT = 4, parameter N_IN = 4,
  parameter PWM_CYCLES = 1280) (
  input wire clk_sys_i,
  input wire reset_i,
  input wire [N_OUT-1:0] event_output_lines_o,
  input wire buffered_clock_output_o,
  input wire [15:0] base_timer_o,
  input wire [15:0] timer2_o,
  input wire [N_IN-1:0] evt_level_o,
  input wire pwm_o
);
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (reset_i);
  logic [4:0] bcnt;
  logic [11:0] pcnt;
  logic bok, pok, t2ok;
  // Gap counters; first span after reset is not judged
  always_ff @(posedge clk_sys_i) begin
    bcnt <= $changed(base_timer_o) ? 5'h1 : bcnt + 5'h1;
    pcnt <= $rose(pwm_o) ? 12'h1 : pcnt + 12'h1;
    bok <= !reset_i && (bok || $changed(base_timer_o));
    pok <= !reset_i && (pok || $rose(pwm_o));
    if (reset_i || $changed(timer2_o)) begin
      t2ok <= 1'b0;
    end else if ($changed(base_timer_o)) begin
      t2ok <= 1'b1;
    end
  end
  AST_OUT_SYNC: assert property ($changed(event_output_lines_o) |->
    base_timer_o == $past(base_timer_o) + 16'h1) else $error("line moved off tick");
  AST_OUT_RISE: assert property ($changed(event_output_lines_o) |->
    $rose(buffered_clock_output_o)) else $error("line change not before rise");
  AST_BT_PERIOD: assert property ($changed(base_timer_o) && bok |->
    bcnt == 5'h18) else $error("tick spacing not 24");
  AST_BT_STEP: assert property ($changed(base_timer_o) |->
    base_timer_o == $past(base_timer_o) + 16'h1) else $error("timer step");
  AST_CLK_SHAPE: assert property ($rose(buffered_clock_output_o) |=>
    !buffered_clock_output_o ##1 !buffered_clock_output_o
    ##1 buffered_clock_output_o) else $error("clock shape");
  AST_T2_SLOW: assert property ($changed(timer2_o) |->
    t2ok || $changed(base_timer_o)) else $error("timer2 too fast");
  AST_LEVEL_ONCE: assert property ($changed(evt_level_o) |=>
    $stable(evt_level_o) [*2]) else $error("sampled twice in a state");
  AST_PWM_PERIOD: assert property ($rose(pwm_o) && pok |->
    pcnt == PWM_CYCLES) else $error("pwm period");
  COV_OUT: cover property ($changed(event_output_lines_o));
  COV_T2: cover property ($changed(timer2_o));
  COV_PWM: cover property ($rose(pwm_o) && pok);
endmodule
bind evt_io_timer_sync evt_chk #(.N_OUT(N_OUT), .N_IN(N_IN),
  .PWM_CYCLES(PWM_CYCLES)) chk_u (.clk_sys_i, .reset_i,
  .event_output_lines_o, .buffered_clock_output_o, .base_timer_o,
  .timer2_o, .evt_level_o, .pwm_o);
`default_nettype wire

/* File: evt_far_model.sv */
// Outside logic timed by the buffered clock.
// Assumes the bench says which input levels it wants.
`timescale 1ns/1ps
`default_nettype none
module evt_far_model #(parameter N = 4) (
  input wire logic bclk_i,
  input wire logic [N-1:0] lines_i,
  input wire logic [N-1:0] want_i,
  output logic [N-1:0] seen_o,
  output logic [N-1:0] pins_o
);
  initial begin
    seen_o = '0;
    pins_o = '0;
  end
  // Capture where outputs are settled
  always @(negedge bclk_i) seen_o <= lines_i;
  // Launch on the fall: each level stands a state time
  always @(negedge bclk_i) pins_o <= want_i;
endmodule
`default_nettype wire

/* File: test_event_io_timer_sync.sv */
// Self-checking bench for the event I/O block.
// Inputs change on the falling clock; far-side model on pins.
`timescale 1ns/1ps
`default_nettype none
module test_event_io_timer_sync;
  logic clk_sys_i = 1'b0, reset_i = 1'b1, vld = 1'b0, t2 = 1'b0;
  logic [3:0] val = 4'h0, msk = 4'h0, want = 4'h0, ack = 4'h0, exp_l = 4'h0;
  logic [3:0] d8 = 4'h0;
  logic [15:0] stime = 16'h0, b0 = 16'h0;
  logic [11:0] duty = 12'h0;
  logic [31:0] rs = 32'h7AE6B3C7;
  int errors = 0, tests_run = 0, k;
  wire [3:0] lines, pend, pins, seen, lvl;
  wire [15:0] bt, t2v, stamp;
  wire bclk, pwm;
  always #25 clk_sys_i = ~clk_sys_i;
  evt_io_timer_sync #(.PWM_CYCLES(16)) dut_u (.clk_sys_i(clk_sys_i),
    .reset_i(reset_i), .sched_value_i(val), .sched_mask_i(msk),
    .sched_time_i(stime), .sched_valid_i(vld), .timer2_ext_i(t2),
    .event_input_pins_i(pins), .div8_mode_i(d8), .evt_ack_i(ack),
    .pwm_duty_i(duty), .event_output_lines_o(lines),
    .buffered_clock_output_o(bclk), .base_timer_o(bt), .timer2_o(t2v),
    .evt_pending_o(pend), .evt_stamp_o(stamp), .evt_level_o(lvl),
    .pwm_o(pwm));
  evt_far_model far_u (.bclk_i(bclk), .lines_i(lines), .want_i(want),
    .seen_o(seen), .pins_o(pins));
  function automatic logic [31:0] xs(input logic [31:0] x);
    x ^= x << 13;
    x ^= x >> 17;
    return x ^ (x << 5);
  endfunction
  // Untouched lines keep their level
  function automatic logic [3:0] merge(input logic [3:0] o, v, m);
    return (o & ~m) | (v & m);
  endfunction
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      errors++;
      $display("ERROR %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic complete_run;
    $display("errors %0d of %0d", errors, tests_run);
    if (errors == 0 && tests_run > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  // Bounded wait for a base timer value
  task automatic till(input logic [15:0] t);
    for (k = 0; k < 200 && bt !== t; k++) @(negedge clk_sys_i);
  endtask
  task automatic steps(input int n);
    repeat (n) @(negedge clk_sys_i);
  endtask
  initial begin
    #1000000;
    errors++;
    complete_run;
  end
  initial begin
    steps(3);
    reset_i = 1'b0;
    check({lines, pend, bt}, 24'h0);
    // Back-to-back schedules with random masks
    for (int i = 0; i < 6; i++) begin
      rs = xs(rs);
      val = rs[3:0];
      msk = i == 0 ? 4'hF : rs[7:4];
      stime = bt + 16'h2;
      vld = 1'b1;
      steps(1);
      vld = 1'b0;
      t2 = ~t2;
      till(stime);
      check(lines, exp_l);
      exp_l = merge(exp_l, val, msk);
      till(stime + 16'h1);
      check(lines, exp_l);
      steps(6);
      check(seen, exp_l);
    end
    // Three rises on the second timer pin, each in its own window
    check(t2v, 16'h3);
    // Several pins rise together; all recorded
    rs = xs(rs);
    want = rs[3:0] | 4'h1;
    b0 = bt;
    steps(30);
    check(pend, want);
    check(lvl, want);
    check(stamp == b0 || stamp == b0 + 16'h1, 1'b1);
    ack = 4'hF;
    want = 4'h0;
    steps(1);
    ack = 4'h0;
    check(pend, 4'h0);
    // Shortest legal pulse: one state time
    want = 4'h2;
    steps(3);
    want = 4'h0;
    steps(30);
    check(pend, 4'h2);
    // Second rise on one pin inside one window is dropped
    ack = 4'hF;
    till(bt + 16'h1);
    ack = 4'h0;
    want = 4'h1;
    steps(3);
    want = 4'h0;
    steps(3);
    check(pend, 4'h1);
    ack = 4'h1;
    want = 4'h1;
    steps(1);
    ack = 4'h0;
    steps(2);
    want = 4'h0;
    steps(20);
    check(pend, 4'h0);
    // Divide-by-eight: only the eighth one-state pulse is recorded
    d8 = 4'h8;
    repeat (8) begin
      check(pend, 4'h0);
      want = 4'h8;
      steps(3);
      want = 4'h0;
      steps(3);
    end
    steps(6);
    check(pend, 4'h8);
    duty = {8'h0, rs[7:4] | 4'h1};
    steps(40);
    k = 0;
    repeat (16) begin
      @(negedge clk_sys_i);
      k += (pwm === 1'b1);
    end
    check(k[15:0], duty);
    complete_run;
  end
endmodule
`default_nettype wire
